/* File: core/cis_cfg.svh */
// constants for the interrupt sequencer
`ifndef CIS_CFG_SVH
`define CIS_CFG_SVH
`define CIS_LVL_WDT 3'h7
`define CIS_LVL_RST 3'h0
`define CIS_BASE_CYC 5'h12
`define CIS_BYTE_BUS_CYC 5'h14
`define CIS_DBC_EXTRA 5'h02
`define CIS_ONE_EXTRA 5'h01
`define CIS_MAX_WAIT 6'h1E
`define CIS_SOFT_LO 6'h20
`define CIS_FLG_I 0
`define CIS_FLG_D 1
`define CIS_FLG_U 2
`define CIS_NUM_WDT 6'h00
`define CIS_NUM_DBC 6'h01
`define CIS_NUM_STEP 6'h02
`define CIS_NUM_AM0 6'h03
`define CIS_NUM_AM1 6'h04
`define CIS_NUM_PERI 6'h08
`endif

/* File: core/cis_pkg.sv */
// types for the interrupt sequencer
`default_nettype none
package cis_pkg;
	typedef enum logic [2:0] {
		CIS_IDLE = 3'b000,
		CIS_WAIT = 3'b001,
		CIS_SEQ = 3'b010,
		CIS_RET = 3'b011
	} cis_state_e;
	typedef enum logic [2:0] {
		CIS_K_NONE = 3'b000,
		CIS_K_RST = 3'b001,
		CIS_K_DBC = 3'b010,
		CIS_K_WDT = 3'b011,
		CIS_K_PERI = 3'b100,
		CIS_K_STEP = 3'b101,
		CIS_K_AM = 3'b110
	} cis_kind_e;
endpackage
`default_nettype wire

/* File: core/cis_arbiter.sv */
// fixed-order and level arbitration of pending requests
`default_nettype none
`include "cis_cfg.svh"
module cis_arbiter #(
	parameter int NSRC = 8
) (
	// sources
	input wire logic [NSRC-1:0] req_i,
	input wire logic [3*NSRC-1:0] level_i,
	input wire logic [2:0] ppl_i,
	input wire logic gie_i,
	// special sources
	input wire logic dbc_i,
	input wire logic wdt_i,
	input wire logic step_i,
	input wire logic am_i,
	// result
	output logic hit_o,
	output cis_pkg::cis_kind_e kind_o,
	output logic [$clog2(NSRC)-1:0] idx_o,
	output logic [2:0] lvl_o
);
	logic peri_hit;
	logic [$clog2(NSRC)-1:0] best;
	logic [2:0] best_lvl;
	// lower index has higher fixed order; strict greater keeps it on ties
	always_comb begin
		peri_hit = 1'b0;
		best = '0;
		best_lvl = 3'h0;
		for (int i = 0; i < NSRC; i++) begin
			if (req_i[i] && gie_i && level_i[3*i +: 3] > ppl_i && (!peri_hit || level_i[3*i +: 3] > best_lvl)) begin
				peri_hit = 1'b1;
				best = i[$clog2(NSRC)-1:0];
				best_lvl = level_i[3*i +: 3];
			end
		end
	end
	// fixed hardware order
	assign kind_o = dbc_i ? cis_pkg::CIS_K_DBC : wdt_i ? cis_pkg::CIS_K_WDT : peri_hit ? cis_pkg::CIS_K_PERI :
		step_i ? cis_pkg::CIS_K_STEP : am_i ? cis_pkg::CIS_K_AM : cis_pkg::CIS_K_NONE;
	assign hit_o = kind_o != cis_pkg::CIS_K_NONE;
	assign idx_o = best;
	assign lvl_o = best_lvl;
endmodule
`default_nettype wire

/* File: core/cis_keyin.sv */
// key-input falling edge detector
`default_nettype none
`include "cis_cfg.svh"
module cis_keyin #(
	parameter int NKEY = 8
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [NKEY-1:0] key_i,
	input wire logic [NKEY-1:0] key_in_dir_i,
	output logic edge_o
);
	logic any_low;
	logic any_low_reg;
	// enabled low keys combined by OR, so one held low hides the others
	assign any_low = |(~key_i & key_in_dir_i);
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			any_low_reg <= 1'b0;
		end else begin
			any_low_reg <= any_low;
		end
	end
	assign edge_o = any_low && !any_low_reg;
endmodule
`default_nettype wire

/* File: core/cis_sequencer.sv */
// interrupt acceptance, stacking and return sequencer
`default_nettype none
`include "cis_cfg.svh"
module cis_sequencer #(
	parameter int NSRC = 8,
	parameter int NKEY = 8
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// peripheral requests
	input wire logic [NSRC-1:0] peri_set_i,
	input wire logic [NSRC-1:0] peri_clr_i,
	input wire logic [3*NSRC-1:0] peri_level_i,
	// special sources
	input wire logic dbc_i,
	input wire logic wdt_i,
	input wire logic step_i,
	input wire logic [NKEY-1:0] key_i,
	input wire logic [NKEY-1:0] key_in_dir_i,
	// address match
	input wire logic [1:0] am_en_i,
	input wire logic [19:0] am_addr0_i,
	input wire logic [19:0] am_addr1_i,
	// core interface
	input wire logic insn_done_i,
	input wire logic first_insn_i,
	input wire logic [19:0] pc_i,
	input wire logic [10:0] flag_i,
	input wire logic [15:0] isp_i,
	input wire logic [15:0] usp_i,
	input wire logic soft_i,
	input wire logic [5:0] soft_num_i,
	input wire logic reti_i,
	input wire logic byte_bus_i,
	input wire logic queue_ready_i,
	input wire logic sw_info_rd_i,
	input wire logic [19:0] vec_addr_i,
	input wire logic [15:0] rd_data_i,
	// core outputs
	output logic busy_o,
	output logic done_o,
	output logic [2:0] ppl_o,
	output logic [10:0] flag_o,
	output logic [19:0] pc_o,
	output logic [5:0] num_o,
	output logic use_usp_o,
	output logic [15:0] sp_o,
	output logic wake_o,
	output logic key_pend_o,
	output logic [NSRC-1:0] peri_req_o,
	output logic [4:0] seq_len_o,
	// stack bus
	output logic bus_rd_o,
	output logic bus_wr_o,
	output logic [19:0] bus_addr_o,
	output logic [15:0] bus_wdata_o,
	output logic bus_byte_o
);
	localparam int IW = $clog2(NSRC);
	cis_pkg::cis_state_e state_reg, state_next;
	logic [NSRC-1:0] req_reg;
	logic [2:0] ppl_reg;
	logic [10:0] flag_reg;
	logic [19:0] pc_reg;
	logic [5:0] num_reg;
	logic use_usp_reg;
	logic [15:0] sp_reg;
	logic [4:0] slot_reg;
	logic [4:0] len_reg;
	logic [4:0] cnt_reg;
	logic busy_reg, done_reg, wake_reg, key_reg;
	logic bus_rd_reg, bus_wr_reg, bus_byte_reg;
	logic [19:0] bus_addr_reg;
	logic [15:0] bus_wdata_reg;
	logic [15:0] ret_lo_reg;
	logic [15:0] saved_hi_reg;
	logic [19:0] ret_pc_reg;
	cis_pkg::cis_kind_e kind_reg;
	logic [IW-1:0] idx_reg;
	logic [2:0] lvl_reg;
	logic first_reg;
	logic [10:0] saved_flag_reg;
	logic hit, key_edge, am_hit, soft_hi, odd_sp, info_rd, accept;
	cis_pkg::cis_kind_e kind;
	logic [IW-1:0] idx;
	logic [2:0] lvl;
	logic [15:0] sel_sp;
	logic [4:0] len_calc;
	logic [2:0] new_ppl;
	logic [15:0] hi_word;
	logic [4:0] bus_slot;
	logic am0_hit;
	cis_pkg::cis_kind_e sw_kind;
	logic [IW-1:0] sw_idx;

	// sequence length in bus clock slots
	function automatic logic [4:0] cis_len(input logic byte_bus, input logic vodd, input logic sodd,
			input cis_pkg::cis_kind_e k);
		logic [4:0] b;
		b = byte_bus ? `CIS_BYTE_BUS_CYC : `CIS_BASE_CYC + {4'h0, vodd} + {4'h0, sodd};
		if (k == cis_pkg::CIS_K_DBC) begin
			b = b + `CIS_DBC_EXTRA;
		end else if (k == cis_pkg::CIS_K_STEP || k == cis_pkg::CIS_K_AM) begin
			b = b + `CIS_ONE_EXTRA;
		end
		return b;
	endfunction

	cis_keyin #(.NKEY(NKEY)) u_key (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.key_i(key_i),
		.key_in_dir_i(key_in_dir_i),
		.edge_o(key_edge)
	);

	assign am0_hit = am_en_i[0] && pc_i == am_addr0_i;
	assign am_hit = am0_hit || (am_en_i[1] && pc_i == am_addr1_i);

	cis_arbiter #(.NSRC(NSRC)) u_arb (
		.req_i(req_reg),
		.level_i(peri_level_i),
		.ppl_i(ppl_reg),
		.gie_i(flag_reg[`CIS_FLG_I]),
		.dbc_i(dbc_i),
		.wdt_i(wdt_i),
		.step_i(step_i),
		.am_i(am_hit),
		.hit_o(hit),
		.kind_o(kind),
		.idx_o(idx),
		.lvl_o(lvl)
	);

	// software read picks its victim regardless of the enable flag
	cis_arbiter #(.NSRC(NSRC)) u_arb_sw (
		.req_i(req_reg),
		.level_i(peri_level_i),
		.ppl_i(ppl_reg),
		.gie_i(1'b1),
		.dbc_i(1'b0),
		.wdt_i(1'b0),
		.step_i(1'b0),
		.am_i(1'b0),
		.hit_o(),
		.kind_o(sw_kind),
		.idx_o(sw_idx),
		.lvl_o()
	);

	// first instruction after reset is never interrupted
	assign accept = state_reg == cis_pkg::CIS_WAIT && insn_done_i && !first_reg && !first_insn_i &&
		(hit || soft_i);
	assign soft_hi = soft_i && soft_num_i >= `CIS_SOFT_LO;
	assign sel_sp = (soft_hi && flag_reg[`CIS_FLG_U]) ? usp_i : isp_i;
	assign odd_sp = sel_sp[0];
	assign len_calc = cis_len(byte_bus_i, vec_addr_i[0], odd_sp, soft_i ? cis_pkg::CIS_K_NONE : kind);
	assign new_ppl = soft_i ? ppl_reg : kind == cis_pkg::CIS_K_PERI ? lvl : kind == cis_pkg::CIS_K_WDT ?
		`CIS_LVL_WDT : ppl_reg;
	// flags as they stood before the sequence cleared them
	assign hi_word = {pc_reg[19:16], saved_flag_reg[10:8], 1'b0, saved_flag_reg[7:0]};
	// even pointer skips the two upper-byte slots
	assign bus_slot = (!sp_reg[0] && slot_reg >= 5'h04) ? slot_reg + 5'h02 : slot_reg;
	assign info_rd = sw_info_rd_i || (state_reg == cis_pkg::CIS_SEQ && slot_reg == 5'h00);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			cis_pkg::CIS_IDLE: begin
				state_next = cis_pkg::CIS_WAIT;
			end
			cis_pkg::CIS_WAIT: begin
				if (accept) begin
					state_next = cis_pkg::CIS_SEQ;
				end else if (reti_i) begin
					state_next = cis_pkg::CIS_RET;
				end
			end
			cis_pkg::CIS_SEQ: begin
				if (cnt_reg == len_reg - 5'h01) begin
					state_next = cis_pkg::CIS_WAIT;
				end
			end
			cis_pkg::CIS_RET: begin
				if (slot_reg == 5'h03) begin
					state_next = cis_pkg::CIS_WAIT;
				end
			end
			default: begin
				state_next = cis_pkg::CIS_IDLE;
			end
		endcase
	end

	// request bits: set wins over clear
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			req_reg <= '0;
		end else begin
			for (int i = 0; i < NSRC; i++) begin
				if (peri_set_i[i]) begin
					req_reg[i] <= 1'b1;
				end else if (peri_clr_i[i] || (info_rd && kind_reg == cis_pkg::CIS_K_PERI && idx_reg == i[IW-1:0]) ||
						(sw_info_rd_i && sw_kind == cis_pkg::CIS_K_PERI && sw_idx == i[IW-1:0])) begin
					req_reg[i] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_reg <= cis_pkg::CIS_IDLE;
			ppl_reg <= `CIS_LVL_RST;
			flag_reg <= '0;
			sp_reg <= '0;
			first_reg <= 1'b1;
			key_reg <= 1'b0;
			wake_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			wake_reg <= key_edge;
			if (key_edge) begin
				key_reg <= 1'b1;
			end else if (info_rd && kind_reg == cis_pkg::CIS_K_PERI) begin
				key_reg <= 1'b0;
			end
			if (insn_done_i) begin
				first_reg <= 1'b0;
			end
			if (state_reg == cis_pkg::CIS_WAIT && !accept) begin
				flag_reg <= flag_i;
			end else if (accept) begin
				flag_reg[`CIS_FLG_I] <= 1'b0;
				flag_reg[`CIS_FLG_D] <= 1'b0;
				if (!soft_hi) begin
					flag_reg[`CIS_FLG_U] <= 1'b0;
				end
				ppl_reg <= new_ppl;
				sp_reg <= sel_sp;
			end else if (state_reg == cis_pkg::CIS_SEQ && cnt_reg == len_reg - 5'h01) begin
				sp_reg <= sp_reg - 16'h0004;
			end else if (state_reg == cis_pkg::CIS_RET && slot_reg == 5'h03) begin
				// the zero filler sits at bit 8 of the saved word
				flag_reg <= {saved_hi_reg[11:9], saved_hi_reg[7:0]};
				sp_reg <= sp_reg + 16'h0004;
			end
		end
	end

	// sequence bookkeeping
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			pc_reg <= '0;
			num_reg <= '0;
			use_usp_reg <= 1'b0;
			len_reg <= '0;
			cnt_reg <= '0;
			slot_reg <= '0;
			kind_reg <= cis_pkg::CIS_K_NONE;
			idx_reg <= '0;
			lvl_reg <= '0;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
			saved_hi_reg <= '0;
			ret_pc_reg <= '0;
			saved_flag_reg <= '0;
		end else begin
			done_reg <= 1'b0;
			if (accept) begin
				pc_reg <= pc_i;
				num_reg <= soft_i ? soft_num_i : kind == cis_pkg::CIS_K_PERI ? `CIS_NUM_PERI + {{(6 - IW){1'b0}}, idx} :
					kind == cis_pkg::CIS_K_WDT ? `CIS_NUM_WDT : kind == cis_pkg::CIS_K_DBC ? `CIS_NUM_DBC :
					kind == cis_pkg::CIS_K_STEP ? `CIS_NUM_STEP : am0_hit ? `CIS_NUM_AM0 : `CIS_NUM_AM1;
				saved_flag_reg <= flag_reg;
				use_usp_reg <= soft_hi && flag_reg[`CIS_FLG_U];
				len_reg <= len_calc;
				kind_reg <= soft_i ? cis_pkg::CIS_K_NONE : kind;
				idx_reg <= idx;
				lvl_reg <= lvl;
				cnt_reg <= '0;
				slot_reg <= '0;
				busy_reg <= 1'b1;
			end else if (state_reg == cis_pkg::CIS_SEQ) begin
				cnt_reg <= cnt_reg + 5'h01;
				if (slot_reg < 5'h08) begin
					slot_reg <= slot_reg + 5'h01;
				end
				if (cnt_reg == len_reg - 5'h01) begin
					busy_reg <= 1'b0;
					done_reg <= 1'b1;
					kind_reg <= cis_pkg::CIS_K_NONE;
				end
			end else if (state_next == cis_pkg::CIS_RET || state_reg == cis_pkg::CIS_RET) begin
				busy_reg <= state_next == cis_pkg::CIS_RET;
				slot_reg <= state_reg == cis_pkg::CIS_RET ? slot_reg + 5'h01 : 5'h00;
				if (state_reg == cis_pkg::CIS_RET && slot_reg == 5'h01) begin
					ret_pc_reg[15:0] <= rd_data_i;
				end
				if (state_reg == cis_pkg::CIS_RET && slot_reg == 5'h02) begin
					saved_hi_reg <= rd_data_i;
					ret_pc_reg[19:16] <= rd_data_i[15:12];
				end
				if (state_reg == cis_pkg::CIS_RET && slot_reg == 5'h03) begin
					done_reg <= 1'b1;
					pc_reg <= ret_pc_reg;
				end
			end
		end
	end

	// stack bus slots: info, queue slot, SP-2, SP-4, vec, vec+2
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			bus_rd_reg <= 1'b0;
			bus_wr_reg <= 1'b0;
			bus_byte_reg <= 1'b0;
			bus_addr_reg <= '0;
			bus_wdata_reg <= '0;
		end else begin
			bus_rd_reg <= 1'b0;
			bus_wr_reg <= 1'b0;
			bus_byte_reg <= 1'b0;
			if (state_reg == cis_pkg::CIS_SEQ) begin
				case (bus_slot)
					5'h00: begin
						bus_rd_reg <= 1'b1;
						bus_addr_reg <= '0;
					end
					5'h01: begin
						bus_rd_reg <= queue_ready_i;
						bus_addr_reg <= pc_reg;
					end
					5'h02: begin
						bus_wr_reg <= 1'b1;
						bus_byte_reg <= sp_reg[0];
						bus_addr_reg <= {4'h0, sp_reg - 16'h0002};
						bus_wdata_reg <= hi_word;
					end
					5'h03: begin
						bus_wr_reg <= 1'b1;
						bus_byte_reg <= sp_reg[0];
						bus_addr_reg <= {4'h0, sp_reg - 16'h0004};
						bus_wdata_reg <= pc_reg[15:0];
					end
					// odd pointer only: upper bytes of both words follow
					5'h04: begin
						bus_wr_reg <= 1'b1;
						bus_byte_reg <= 1'b1;
						bus_addr_reg <= {4'h0, sp_reg - 16'h0001};
						bus_wdata_reg <= {8'h00, hi_word[15:8]};
					end
					5'h05: begin
						bus_wr_reg <= 1'b1;
						bus_byte_reg <= 1'b1;
						bus_addr_reg <= {4'h0, sp_reg - 16'h0003};
						bus_wdata_reg <= {8'h00, pc_reg[15:8]};
					end
					5'h06: begin
						bus_rd_reg <= 1'b1;
						bus_addr_reg <= vec_addr_i;
					end
					5'h07: begin
						bus_rd_reg <= 1'b1;
						bus_addr_reg <= vec_addr_i + 20'h00002;
					end
					default: begin
						bus_addr_reg <= bus_addr_reg;
					end
				endcase
			end else if (state_reg == cis_pkg::CIS_RET && slot_reg < 5'h02) begin
				bus_rd_reg <= 1'b1;
				bus_addr_reg <= {4'h0, slot_reg == 5'h00 ? sp_reg : sp_reg + 16'h0002};
			end
		end
	end

	// outputs straight from flops
	assign busy_o = busy_reg;
	assign done_o = done_reg;
	assign ppl_o = ppl_reg;
	assign flag_o = flag_reg;
	assign pc_o = pc_reg;
	assign num_o = num_reg;
	assign use_usp_o = use_usp_reg;
	assign sp_o = sp_reg;
	assign wake_o = wake_reg;
	assign key_pend_o = key_reg;
	assign peri_req_o = req_reg;
	assign seq_len_o = len_reg;
	assign bus_rd_o = bus_rd_reg;
	assign bus_wr_o = bus_wr_reg;
	assign bus_addr_o = bus_addr_reg;
	assign bus_wdata_o = bus_wdata_reg;
	assign bus_byte_o = bus_byte_reg;

	// checks
	property p_len_even;
		@(posedge clk_i) disable iff (reset_i)
		(accept && !byte_bus_i && !soft_i && kind == cis_pkg::CIS_K_PERI && !vec_addr_i[0] && !odd_sp) |=> len_reg == 5'h12;
	endproperty
	a_len_even: assert property (p_len_even) else $error("even sequence not 18");
	property p_len_byte;
		@(posedge clk_i) disable iff (reset_i)
		(accept && byte_bus_i && kind == cis_pkg::CIS_K_DBC && !soft_i) |=> len_reg == 5'h16;
	endproperty
	a_len_byte: assert property (p_len_byte) else $error("byte bus break not 22");
	property p_wdt_ppl;
		@(posedge clk_i) disable iff (reset_i)
		(accept && !soft_i && kind == cis_pkg::CIS_K_WDT) |=> ppl_o == 3'h7;
	endproperty
	a_wdt_ppl: assert property (p_wdt_ppl) else $error("watchdog level not 7");
	property p_info_first;
		@(posedge clk_i) disable iff (reset_i)
		$rose(busy_o) && state_reg == cis_pkg::CIS_SEQ |=> bus_rd_o && bus_addr_o == 20'h00000;
	endproperty
	a_info_first: assert property (p_info_first) else $error("info read not first");
	property p_push_order;
		@(posedge clk_i) disable iff (reset_i)
		$rose(busy_o) && state_reg == cis_pkg::CIS_SEQ |=> ##2 bus_wr_o && bus_wdata_o == hi_word ##1
			bus_wr_o && bus_wdata_o == pc_reg[15:0];
	endproperty
	a_push_order: assert property (p_push_order) else $error("push order wrong");
	property p_byte_odd;
		@(posedge clk_i) disable iff (reset_i)
		bus_wr_o && state_reg == cis_pkg::CIS_SEQ |-> bus_byte_o == sp_reg[0];
	endproperty
	a_byte_odd: assert property (p_byte_odd) else $error("access width wrong");
	property p_flags_clr;
		@(posedge clk_i) disable iff (reset_i)
		accept |=> !flag_o[`CIS_FLG_I] && !flag_o[`CIS_FLG_D];
	endproperty
	a_flags_clr: assert property (p_flags_clr) else $error("flags not cleared");
	property p_no_first;
		@(posedge clk_i) disable iff (reset_i)
		first_reg |-> !accept;
	endproperty
	a_no_first: assert property (p_no_first) else $error("first instruction interrupted");
	property p_done_len;
		@(posedge clk_i) disable iff (reset_i)
		$rose(busy_o) && state_reg == cis_pkg::CIS_SEQ |-> ##[17:23] done_o;
	endproperty
	a_done_len: assert property (p_done_len) else $error("sequence length out of range");
endmodule
`default_nettype wire

/* File: tb/cis_stack_mem.sv */
// stack memory partner answering the sequencer's bus strobes
`default_nettype none
module cis_stack_mem (
	// clock
	input wire logic clk_i,
	// sequencer bus
	input wire logic bus_rd_i,
	input wire logic bus_wr_i,
	input wire logic [19:0] bus_addr_i,
	input wire logic [15:0] bus_wdata_i,
	input wire logic bus_byte_i,
	// read data
	output logic [15:0] rd_data_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [int];
	logic [15:0] last = 16'h0000;
	int log_q[$];
	function automatic logic [15:0] rd16(input int a);
		logic [7:0] lo;
		logic [7:0] hi;
		lo = mem.exists(a) ? mem[a] : 8'h5A;
		hi = mem.exists(a + 1) ? mem[a + 1] : 8'hC3;
		return {hi, lo};
	endfunction
	// idle bus shows the inverse so a late sample never sees stale data
	assign rd_data_o = bus_rd_i ? rd16(int'(bus_addr_i)) : ~last;
	// memory only answers, it never starts a read of its own
	always @(posedge clk_i) begin
		if (bus_rd_i) last <= rd_data_o;
		if (bus_rd_i || bus_wr_i) log_q.push_back((int'(bus_wr_i) << 20) | int'(bus_addr_i));
		if (bus_wr_i) begin
			mem[int'(bus_addr_i)] = bus_wdata_i[7:0];
			if (!bus_byte_i) mem[int'(bus_addr_i) + 1] = bus_wdata_i[15:8];
		end
	end
endmodule
`default_nettype wire

/* File: tb/cpu_interrupt_sequencer_tb_top.sv */
// self-checking bench for the interrupt sequencer
`default_nettype none
`define CHK(g, e, m) begin comparisons++; if ((g) !== (e)) begin errors++; $display("ERROR %0t %s", $time, m); end end
module cpu_interrupt_sequencer_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0, reset_i = 1'b1, dbc_i = 1'b0, wdt_i = 1'b0, step_i = 1'b0, insn_done_i = 1'b0;
	logic first_insn_i = 1'b0, soft_i = 1'b0, reti_i = 1'b0, byte_bus_i = 1'b0, queue_ready_i = 1'b0;
	logic sw_info_rd_i = 1'b0;
	logic [7:0] peri_set_i = 8'h00, peri_clr_i = 8'h00, key_i = 8'hFF, key_in_dir_i = 8'hFF;
	logic [23:0] peri_level_i = 24'h000000;
	logic [1:0] am_en_i = 2'h0;
	logic [19:0] am_addr0_i = 20'h00000, am_addr1_i = 20'h00000, pc_i = 20'h00000, vec_addr_i = 20'hFFFC0;
	logic [10:0] flag_i = 11'h000;
	logic [15:0] isp_i = 16'h0400, usp_i = 16'h0800, rd_data_i;
	logic [5:0] soft_num_i = 6'h00;
	logic busy_o, done_o, use_usp_o, wake_o, key_pend_o, bus_rd_o, bus_wr_o, bus_byte_o;
	logic [2:0] ppl_o;
	logic [10:0] flag_o;
	logic [19:0] pc_o, bus_addr_o;
	logic [5:0] num_o;
	logic [15:0] sp_o, bus_wdata_o;
	logic [7:0] peri_req_o;
	logic [4:0] seq_len_o;
	int errors = 0, comparisons = 0, wakes = 0;
	int e_num, e_len, e_lvl;
	logic e_u;
	cis_sequencer DUT (.*);
	cis_stack_mem MEM (.clk_i(clk_i), .bus_rd_i(bus_rd_o), .bus_wr_i(bus_wr_o), .bus_addr_i(bus_addr_o),
		.bus_wdata_i(bus_wdata_o), .bus_byte_i(bus_byte_o), .rd_data_o(rd_data_i));
	always #4 clk_i = ~clk_i;
	always @(posedge clk_i) if (wake_o === 1'b1) wakes++;
	task automatic conclude;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// inputs always change one nanosecond after the edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic wait_done(output int n);
		n = 0;
		while (done_o !== 1'b1) begin
			tick(1);
			n++;
			if (n > 60) begin
				errors++;
				conclude();
			end
		end
	endtask
	task automatic do_reset;
		reset_i = 1'b1;
		tick(3);
		reset_i = 1'b0;
		tick(2);
		insn_done_i = 1'b1;
		tick(1);
		insn_done_i = 1'b0;
		tick(2);
		`CHK(busy_o, 1'b0, "first boundary taken")
	endtask
	task automatic run_irq(input logic [15:0] sp);
		int n;
		int q[$];
		logic [15:0] hi;
		hi = {pc_i[19:16], flag_i[10:8], 1'b0, flag_i[7:0]};
		q = {0, -1, 32'h100000 | (int'(sp) - 2), 32'h100000 | (int'(sp) - 4), int'(vec_addr_i), int'(vec_addr_i) + 2};
		if (!queue_ready_i) q.delete(1);
		MEM.log_q.delete();
		insn_done_i = 1'b1;
		tick(1);
		insn_done_i = 1'b0;
		soft_i = 1'b0;
		dbc_i = 1'b0;
		wdt_i = 1'b0;
		step_i = 1'b0;
		am_en_i = 2'h0;
		wait_done(n);
		`CHK(n, e_len, "sequence cycles")
		`CHK(seq_len_o, 5'(e_len), "sequence length")
		`CHK(num_o, 6'(e_num), "vector number")
		`CHK(ppl_o, 3'(e_lvl), "priority level")
		`CHK(use_usp_o, e_u, "pointer select")
		`CHK(sp_o, sp - 16'h0004, "pointer after push")
		`CHK(MEM.rd16(int'(sp) - 2), hi, "upper saved word")
		`CHK(MEM.rd16(int'(sp) - 4), pc_i[15:0], "lower saved word")
		`CHK(flag_o[2:0], {e_u & flag_i[2], 2'b00}, "flags cleared")
		if (!byte_bus_i && !sp[0] && !vec_addr_i[0]) begin
			`CHK(MEM.log_q.size(), q.size(), "access count")
			foreach (q[i]) `CHK(q[i] < 0 ? MEM.log_q[i] >> 20 : MEM.log_q[i], q[i] < 0 ? 0 : q[i], "order")
		end
		reti_i = 1'b1;
		tick(1);
		reti_i = 1'b0;
		wait_done(n);
		`CHK(pc_o, pc_i, "restored pc")
		`CHK(flag_o, flag_i, "restored flags")
		`CHK(sp_o, sp, "pointer after return")
	endtask
	initial begin
		void'($urandom(88));
		tick(3);
		reset_i = 1'b0;
		tick(1);
		`CHK(ppl_o, 3'h0, "reset level")
		`CHK(sp_o, 16'h0000, "reset pointer")
		key_i = 8'hFE;
		tick(4);
		`CHK(wakes, 1, "key wake")
		`CHK(key_pend_o, 1'b1, "key pending")
		key_i = 8'hDE;
		tick(4);
		`CHK(wakes, 1, "masked key edge")
		key_i = 8'hFF;
		tick(2);
		key_in_dir_i = 8'hF7;
		key_i = 8'hF7;
		tick(4);
		`CHK(wakes, 1, "output key ignored")
		key_i = 8'hFF;
		tick(2);
		key_in_dir_i = 8'hFF;
		key_i = 8'hF7;
		tick(4);
		`CHK(wakes, 2, "second key wake")
		key_i = 8'hFF;
		do_reset();
		peri_level_i = 24'h0030C0;
		peri_set_i = 8'h54;
		tick(1);
		peri_set_i = 8'h00;
		insn_done_i = 1'b1;
		tick(1);
		insn_done_i = 1'b0;
		tick(1);
		`CHK(busy_o, 1'b0, "taken with enable off")
		// deliberate software read of the info address
		sw_info_rd_i = 1'b1;
		tick(1);
		sw_info_rd_i = 1'b0;
		tick(1);
		`CHK(peri_req_o, 8'h50, "info read clear")
		peri_clr_i = 8'h40;
		tick(1);
		peri_clr_i = 8'h00;
		tick(1);
		`CHK(peri_req_o, 8'h10, "software clear")
		for (int k = 0; k < 8; k++) begin
			// watchdog raised before reset: first boundary must still pass
			wdt_i = (k == 0);
			do_reset();
			pc_i = 20'($urandom());
			flag_i = 11'($urandom()) | 11'h001;
			// pointer loaded before any acceptance
			isp_i = {4'h1, 11'($urandom()), 1'b0};
			usp_i = isp_i ^ 16'h4000;
			byte_bus_i = (k == 5 || k == 3);
			queue_ready_i = k[0];
			vec_addr_i = (k == 4) ? 20'hFFFC5 : 20'hFFFC0;
			e_u = 1'b0;
			e_lvl = 0;
			e_len = 18;
			case (k)
				0: begin
					peri_level_i = 24'h000E00;
					peri_set_i = 8'h08;
					e_num = 0;
					e_lvl = 7;
				end
				1: begin
					peri_level_i = 24'h030100;
					peri_set_i = 8'h24;
					e_num = 13;
					e_lvl = 6;
				end
				2: begin
					peri_level_i = 24'h0C0018;
					peri_set_i = 8'h42;
					isp_i[0] = 1'b1;
					e_num = 9;
					e_lvl = 3;
					e_len = 19;
				end
				3: begin
					dbc_i = 1'b1;
					wdt_i = 1'b1;
					step_i = 1'b1;
					e_num = 1;
					e_len = 22;
				end
				4: begin
					step_i = 1'b1;
					e_num = 2;
					e_len = 20;
				end
				5: begin
					flag_i[0] = 1'b0;
					am_addr0_i = pc_i ^ 20'h00001;
					am_addr1_i = pc_i;
					am_en_i = 2'h3;
					e_num = 4;
					e_len = 21;
				end
				default: begin
					peri_level_i = 24'h000007;
					peri_set_i = 8'h01;
					flag_i[2] = 1'b1;
					soft_i = 1'b1;
					soft_num_i = (k == 6) ? 6'h28 : 6'h05;
					e_num = (k == 6) ? 40 : 5;
					e_u = (k == 6);
				end
			endcase
			tick(1);
			peri_set_i = 8'h00;
			run_irq(e_u ? usp_i : isp_i);
		end
		conclude();
	end
endmodule
`default_nettype wire
